// ### rtl/pjs_pkg.sv
// Package for the program jog sequencer: parameter layouts, defaults, timing.
// Assumes one 40 MHz control clock shared by every user of the package.
package pjs_pkg;

	// ---------------------------------------------------------------
	// Parameter word layouts and defaults
	// ---------------------------------------------------------------
	localparam int          SEL_W            = 16;
	localparam int          PAT_LSB          = 0;
	localparam int          PAT_W            = 4;
	localparam logic [15:0] SEL_DEFAULT      = 16'h0000;
	localparam logic [3:0]  PAT_MAX          = 4'h5;
	localparam int          DIST_W           = 32;
	localparam logic [31:0] DIST_DEFAULT     = 32'h00008000;
	localparam int          SPEED_W          = 16;
	localparam logic [15:0] SPEED_DEFAULT    = 16'h01f4;
	localparam int          RAMP_W           = 16;
	localparam logic [15:0] RAMP_DEFAULT     = 16'h0064;
	localparam int          WAIT_W           = 16;
	localparam logic [15:0] WAIT_DEFAULT     = 16'h0064;
	localparam int          CNT_W            = 16;
	localparam logic [15:0] CNT_DEFAULT      = 16'h0001;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          CLK_HZ           = 40000000;
	localparam int          WAIT_UNIT_US     = 1000;
	localparam int          CYC_PER_MS       = CLK_HZ / 1000000 * WAIT_UNIT_US;
	localparam int          MS_CNT_W         = 16;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [SEL_W-1:0]   selection;
		logic [DIST_W-1:0]  distance;
		logic [SPEED_W-1:0] speed;
		logic [RAMP_W-1:0]  ramp;
		logic [WAIT_W-1:0]  wait_ms;
		logic [CNT_W-1:0]   count;
	} pjs_cfg_t;

	typedef struct packed {
		logic               reverse;
		logic [DIST_W-1:0]  distance;
		logic [SPEED_W-1:0] speed;
		logic [RAMP_W-1:0]  ramp;
	} pjs_move_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_ISSUE = 3'b011,
		ST_MOVE  = 3'b010,
		ST_DONE  = 3'b110
	} pjs_state_t;

endpackage

// ### rtl/pjs_ms_timer.sv
// Millisecond wait timer: counts a loaded number of milliseconds.
// Assumes an asynchronous active-low reset whose release is already synchronized.
`timescale 1ns/1ps
`default_nettype none
module pjs_ms_timer
	import pjs_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  start_i,
	input  wire logic [WAIT_W-1:0]     ms_i,
	output logic                       expired_o
);
	logic [MS_CNT_W-1:0] cyc_ff;
	logic [WAIT_W-1:0]   ms_left_ff;
	logic                run_ff;
	localparam logic [MS_CNT_W-1:0] CYC_LAST = MS_CNT_W'(CYC_MS - 1);

	// Zero wait expires one cycle after start so a wait is never skipped
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_ff     <= 1'b0;
			cyc_ff     <= '0;
			ms_left_ff <= '0;
		end else if (start_i) begin
			run_ff     <= 1'b1;
			cyc_ff     <= '0;
			ms_left_ff <= ms_i;
		end else if (run_ff) begin
			if (ms_left_ff == '0) begin
				run_ff <= 1'b0;
			end else if (cyc_ff == CYC_LAST) begin
				cyc_ff     <= '0;
				ms_left_ff <= ms_left_ff - 1'b1;
			end else begin
				cyc_ff <= cyc_ff + 1'b1;
			end
		end
	end

	assign expired_o = run_ff && (ms_left_ff == '0) && !start_i;
endmodule
`default_nettype wire

// ### rtl/pjs_sequencer.sv
// Program jog sequencer: steps through waits and moves of a jog pattern
// and hands each move to the motion profile generator.
// Assumes the profile generator takes a move on valid/ready and pulses done.
//
// Function
// - Low hex digit of selection word picks pattern 0..5; resets to zero.
// - Patterns 0/1: count times wait then forward (0) or reverse (1) move.
// - Patterns 2/3: count forward then count reverse, or the reverse order.
// - Patterns 4/5: each repetition waits, moves one way, waits, moves back.
// - Each move is preceded by one wait of the waiting time in milliseconds.
`timescale 1ns/1ps
`default_nettype none
module pjs_sequencer
	import pjs_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	input  wire logic               SYS_CLK_I,
	input  wire logic               RST_N_I,
	input  wire pjs_pkg::pjs_cfg_t  CFG_I,
	input  wire logic               CFG_WE_I,
	input  wire logic               START_I,
	input  wire logic               ABORT_I,
	output pjs_pkg::pjs_move_t      MOVE_O,
	output logic                    MOVE_VALID_O,
	input  wire logic               MOVE_READY_I,
	input  wire logic               MOVE_DONE_I,
	output logic                    BUSY_O,
	output logic                    DONE_O,
	output logic [3:0]              PATTERN_O
);
	import pjs_pkg::*;

	// -----------------------------------------------------------------
	// Reset release
	// -----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_sync_n_ff;
	logic rst_n;
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_meta_ff   <= 1'b0;
			rst_sync_n_ff <= 1'b0;
		end else begin
			rst_meta_ff   <= 1'b1;
			rst_sync_n_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_n_ff;

	// -----------------------------------------------------------------
	// Parameter store
	// -----------------------------------------------------------------
	pjs_cfg_t cfg_ff;
	logic     run_go;
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= '{SEL_DEFAULT, DIST_DEFAULT, SPEED_DEFAULT,
			            RAMP_DEFAULT, WAIT_DEFAULT, CNT_DEFAULT};
		end else if (CFG_WE_I) begin
			cfg_ff <= CFG_I;
		end
	end

	// Out-of-range pattern codes are refused at start, not clamped
	logic [3:0] pat;
	assign pat       = cfg_ff.selection[PAT_LSB +: PAT_W];
	assign PATTERN_O = pat;

	// -----------------------------------------------------------------
	// Sequence state
	// -----------------------------------------------------------------
	pjs_state_t        state_ff;
	pjs_state_t        nxt_state;
	logic [3:0]        run_pat_ff;
	logic [CNT_W-1:0]  rep_ff;
	logic              phase_ff;
	logic              half_ff;
	logic              timer_start;
	logic              timer_expired;
	logic              last_move;
	logic              dir_rev;

	assign run_go = START_I && (pat <= PAT_MAX) && !ABORT_I;

	// Direction of the current move from pattern, half and phase
	always_comb begin
		dir_rev = 1'b0;
		unique case (run_pat_ff)
			4'h0:    dir_rev = 1'b0;
			4'h1:    dir_rev = 1'b1;
			4'h2:    dir_rev = half_ff;
			4'h3:    dir_rev = !half_ff;
			4'h4:    dir_rev = phase_ff;
			4'h5:    dir_rev = !phase_ff;
			default: dir_rev = 1'b0;
		endcase
	end

	// Last move: final repetition and, for two-part patterns, second part
	always_comb begin
		last_move = 1'b0;
		unique case (run_pat_ff)
			4'h2, 4'h3: last_move = half_ff && (rep_ff == cfg_ff.count - 1'b1);
			4'h4, 4'h5: last_move = phase_ff && (rep_ff == cfg_ff.count - 1'b1);
			default:    last_move = (rep_ff == cfg_ff.count - 1'b1);
		endcase
	end

	always_comb begin
		nxt_state   = state_ff;
		timer_start = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				if (run_go) begin
					if (cfg_ff.count == '0) begin
						nxt_state = ST_DONE;
					end else begin
						nxt_state   = ST_WAIT;
						timer_start = 1'b1;
					end
				end
			end
			ST_WAIT: begin
				if (timer_expired) begin
					nxt_state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (MOVE_READY_I) begin
					nxt_state = ST_MOVE;
				end
			end
			ST_MOVE: begin
				if (MOVE_DONE_I) begin
					if (last_move) begin
						nxt_state = ST_DONE;
					end else begin
						nxt_state   = ST_WAIT;
						timer_start = 1'b1;
					end
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (ABORT_I && state_ff != ST_IDLE) begin
			nxt_state   = ST_IDLE;
			timer_start = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Pattern latched at start so a rewrite mid-run cannot change direction
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			run_pat_ff <= 4'h0;
		end else if (state_ff == ST_IDLE && run_go) begin
			run_pat_ff <= pat;
		end
	end

	// Repetition, phase and half bookkeeping advanced at each move end but the last
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rep_ff   <= '0;
			phase_ff <= 1'b0;
			half_ff  <= 1'b0;
		end else if (state_ff == ST_IDLE) begin
			rep_ff   <= '0;
			phase_ff <= 1'b0;
			half_ff  <= 1'b0;
		end else if (state_ff == ST_MOVE && MOVE_DONE_I && !last_move) begin
			if (run_pat_ff == 4'h4 || run_pat_ff == 4'h5) begin
				phase_ff <= !phase_ff;
				if (phase_ff) begin
					rep_ff <= rep_ff + 1'b1;
				end
			end else if (rep_ff == cfg_ff.count - 1'b1) begin
				rep_ff  <= '0;
				half_ff <= 1'b1;
			end else begin
				rep_ff <= rep_ff + 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Wait timer and outputs
	// -----------------------------------------------------------------
	pjs_ms_timer #(
		.CYC_MS    (CYC_MS)
	) u_timer (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (rst_n),
		.start_i   (timer_start),
		.ms_i      (cfg_ff.wait_ms),
		.expired_o (timer_expired)
	);

	// Move data held steady for the whole request
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			MOVE_O <= '0;
		end else if (state_ff == ST_WAIT) begin
			MOVE_O <= '{dir_rev, cfg_ff.distance, cfg_ff.speed, cfg_ff.ramp};
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			DONE_O <= 1'b0;
		end else begin
			DONE_O <= (state_ff == ST_DONE);
		end
	end

	assign MOVE_VALID_O = (state_ff == ST_ISSUE);
	assign BUSY_O       = (state_ff != ST_IDLE);

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	property p_zero_count;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(state_ff == ST_IDLE && run_go && cfg_ff.count == '0)
			|-> !MOVE_VALID_O [*2] ##1 DONE_O;
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("zero count issued move");

	property p_wait_before_move;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		$rose(MOVE_VALID_O) |-> $past(state_ff) == ST_WAIT;
	endproperty
	a_wait_before_move: assert property (p_wait_before_move) else $error("move without wait");

	property p_fwd_only;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(MOVE_VALID_O && run_pat_ff == 4'h0) |-> !MOVE_O.reverse;
	endproperty
	a_fwd_only: assert property (p_fwd_only) else $error("pattern 0 reversed");

	property p_rev_only;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(MOVE_VALID_O && run_pat_ff == 4'h1) |-> MOVE_O.reverse;
	endproperty
	a_rev_only: assert property (p_rev_only) else $error("pattern 1 forward");

	property p_halves;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(MOVE_VALID_O && run_pat_ff == 4'h2) |-> MOVE_O.reverse == half_ff;
	endproperty
	a_halves: assert property (p_halves) else $error("pattern 2 order wrong");

	property p_alternate;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(MOVE_VALID_O && run_pat_ff == 4'h5) |-> MOVE_O.reverse != phase_ff;
	endproperty
	a_alternate: assert property (p_alternate) else $error("pattern 5 order wrong");

	property p_bad_pattern;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(state_ff == ST_IDLE && START_I && pat > PAT_MAX) |=> state_ff == ST_IDLE;
	endproperty
	a_bad_pattern: assert property (p_bad_pattern) else $error("illegal pattern ran");

	property p_valid_holds;
		@(posedge SYS_CLK_I) disable iff (!rst_n)
		(MOVE_VALID_O && !MOVE_READY_I && !ABORT_I) |=> MOVE_VALID_O && $stable(MOVE_O);
	endproperty
	a_valid_holds: assert property (p_valid_holds) else $error("request dropped");

	c_run: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) $rose(DONE_O));
	c_alt: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		MOVE_VALID_O && run_pat_ff == 4'h4 && phase_ff);
	c_half: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n)
		MOVE_VALID_O && run_pat_ff == 4'h3 && half_ff);
endmodule
`default_nettype wire

// ### tb/pjs_gen_model.sv
// Motion profile generator model: takes moves on valid/ready, pulses done.
// Assumes one clock and the sequencer's active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pjs_gen_model (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic valid_i,
	input  wire logic slow_i,
	output logic      ready_o,
	output logic      done_o
);
	logic [3:0] cnt_ff;
	logic       busy_ff;
	logic       ready_ff;
	logic       done_ff;

	assign ready_o = ready_ff;
	assign done_o  = done_ff;

	// Slow mode stalls acceptance and stretches the move, to test both paces
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff   <= 4'h0;
			busy_ff  <= 1'b0;
			ready_ff <= 1'b0;
			done_ff  <= 1'b0;
		end else begin
			ready_ff <= 1'b0;
			done_ff  <= 1'b0;
			if (busy_ff) begin
				if (cnt_ff == 4'h0) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else
					cnt_ff <= cnt_ff - 4'h1;
			end else if (valid_i && !ready_ff) begin
				if (cnt_ff == 4'h0) begin
					ready_ff <= 1'b1;
					busy_ff  <= 1'b1;
					cnt_ff   <= slow_i ? 4'h6 : 4'h1;
				end else
					cnt_ff <= cnt_ff - 4'h1;
			end else
				cnt_ff <= slow_i ? 4'h3 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Bench for the program jog sequencer: pattern table, zero count, refusal, reset.
// Assumes the generator model beside it and a shortened millisecond.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pjs_pkg::*;
	localparam int          CYCMS     = 4;
	localparam int          WAITC     = 2 * CYCMS;
	localparam int          CYC_LIMIT = 20000;
	localparam logic [31:0] DIST      = 32'h00001234;
	localparam logic [15:0] SPD       = 16'h0123;
	localparam logic [15:0] RMP       = 16'h0045;
	typedef struct packed {
		logic [3:0] pat;
		logic       slow;
		logic [3:0] cnt;
		logic [3:0] nmov;
		logic [7:0] dirs;
	} pjs_row_t;
	pjs_row_t   rows [7] = '{
		'{4'h0, 1'b0, 4'h2, 4'h2, 8'h00}, '{4'h1, 1'b1, 4'h2, 4'h2, 8'h03},
		'{4'h2, 1'b0, 4'h2, 4'h4, 8'h0c}, '{4'h3, 1'b1, 4'h2, 4'h4, 8'h03},
		'{4'h4, 1'b0, 4'h3, 4'h6, 8'h2a}, '{4'h5, 1'b1, 4'h2, 4'h4, 8'h05},
		'{4'h5, 1'b0, 4'h1, 4'h2, 8'h01}};
	logic       SYS_CLK_I;
	logic       RST_N_I;
	pjs_cfg_t   CFG_I;
	logic       CFG_WE_I;
	logic       START_I;
	logic       ABORT_I;
	pjs_move_t  MOVE_O;
	logic       MOVE_VALID_O;
	logic       MOVE_READY_I;
	logic       MOVE_DONE_I;
	logic       BUSY_O;
	logic       DONE_O;
	logic [3:0] PATTERN_O;
	logic       slow;
	logic       vld_q;
	logic [7:0] got_dirs;
	int         error_cnt;
	int         n_compared;
	int         cyc;
	int         since;
	int         nseen;
	int         t;

	pjs_sequencer #(.CYC_MS(CYCMS)) pjs_sequencer_i (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
		.CFG_I(CFG_I), .CFG_WE_I(CFG_WE_I), .START_I(START_I), .ABORT_I(ABORT_I),
		.MOVE_O(MOVE_O), .MOVE_VALID_O(MOVE_VALID_O), .MOVE_READY_I(MOVE_READY_I),
		.MOVE_DONE_I(MOVE_DONE_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .PATTERN_O(PATTERN_O));
	pjs_gen_model pjs_gen_model_i (.clk_i(SYS_CLK_I), .rst_n_i(RST_N_I), .valid_i(MOVE_VALID_O),
		.slow_i(slow), .ready_o(MOVE_READY_I), .done_o(MOVE_DONE_I));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Upper selection digits always written as zero
	task automatic kick(input logic [3:0] pat, input logic [15:0] cnt);
		nseen = 0;
		got_dirs = 8'h00;
		CFG_I = {12'h000, pat, DIST, SPD, RMP, 16'h0002, cnt};
		CFG_WE_I = 1'b1;
		@(negedge SYS_CLK_I);
		CFG_WE_I = 1'b0;
		START_I = 1'b1;
		@(negedge SYS_CLK_I);
		START_I = 1'b0;
	endtask

	task automatic run_job(input logic [3:0] pat, input logic [15:0] cnt);
		kick(pat, cnt);
		t = 1;
		while (DONE_O !== 1'b1 && t < 3000) begin
			@(negedge SYS_CLK_I);
			t++;
		end
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and handshake monitor
	// ----------------------------------------------------------------
	initial begin
		SYS_CLK_I = 1'b0;
		forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
	end

	always @(posedge SYS_CLK_I) begin
		cyc++;
		if (cyc == CYC_LIMIT) begin
			error_cnt++;
			$display("[FAIL] %0t run did not finish", $time);
			end_sim();
		end
	end

	always @(posedge SYS_CLK_I) begin
		if (MOVE_VALID_O === 1'b1 && vld_q !== 1'b1)
			check(since >= WAITC && since <= WAITC + 5, 1, "wait before move");
		if (MOVE_VALID_O === 1'b1 && MOVE_READY_I === 1'b1) begin
			check(MOVE_O.distance, DIST, "travel distance");
			check(MOVE_O.speed, SPD, "move speed");
			check(MOVE_O.ramp, RMP, "ramp time");
			got_dirs[nseen[2:0]] = MOVE_O.reverse;
			nseen++;
		end
		since = (START_I || MOVE_DONE_I) ? 0 : since + 1;
		vld_q = MOVE_VALID_O;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		RST_N_I = 1'b0;
		CFG_I = {16'h0000, DIST, SPEED_DEFAULT, RAMP_DEFAULT, 16'h0002, 16'h0001};
		CFG_WE_I = 1'b0;
		START_I = 1'b0;
		ABORT_I = 1'b0;
		slow = 1'b0;
		repeat (20) @(negedge SYS_CLK_I);
		check({BUSY_O, DONE_O, MOVE_VALID_O, PATTERN_O}, 0, "reset outputs");
		RST_N_I = 1'b1;
		repeat (4) @(negedge SYS_CLK_I);
		$display("Test reset done");
		foreach (rows[i]) begin
			slow = rows[i].slow;
			run_job(rows[i].pat, {12'h000, rows[i].cnt});
			check(DONE_O, 1, "run completes");
			check(PATTERN_O, rows[i].pat, "pattern");
			check(nseen, rows[i].nmov, "move count");
			check(got_dirs, rows[i].dirs, "move directions");
			$display("Test row %0d done", i);
			@(negedge SYS_CLK_I);
		end
		run_job(4'h0, 16'h0000);
		check(nseen, 0, "zero count moves");
		check(t <= 4, 1, "zero count completion");
		$display("Test zero count done");
		@(negedge SYS_CLK_I);
		kick(4'h6, 16'h0001);
		repeat (3) @(negedge SYS_CLK_I);
		check({BUSY_O, PATTERN_O}, 5'h06, "out of range pattern refused");
		$display("Test refusal done");
		// Abort in mid-wait: back to idle with no move and no completion
		kick(4'h0, 16'h0002);
		repeat (3) @(negedge SYS_CLK_I);
		ABORT_I = 1'b1;
		@(negedge SYS_CLK_I);
		ABORT_I = 1'b0;
		check({BUSY_O, DONE_O, MOVE_VALID_O}, 0, "abort to idle");
		repeat (12) @(negedge SYS_CLK_I);
		check(nseen, 0, "no move after abort");
		$display("Test abort done");
		kick(4'h3, 16'h0002);
		repeat (5) @(negedge SYS_CLK_I);
		check(BUSY_O, 1, "busy during run");
		RST_N_I = 1'b0;
		@(negedge SYS_CLK_I);
		check({BUSY_O, DONE_O, MOVE_VALID_O, PATTERN_O}, 0, "mid-run reset");
		RST_N_I = 1'b1;
		repeat (4) @(negedge SYS_CLK_I);
		run_job(4'h2, 16'h0001);
		check(got_dirs, 8'h02, "run after reset");
		check(nseen, 2, "moves after reset");
		$display("Test mid-run reset done");
		end_sim();
	end
endmodule
`default_nettype wire
